// >>> rtl/chc_engine.sv
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
// Function
// - Hash handles one 512-bit block of 32-bit words; 160 or 256-bit state.
// - Message read at first source offset, initial hash at second; little endian.
// - Schedule scratch at first destination offset: 320 or 256 bytes.
// - Hash written to second destination offset; software chains blocks.
// - 224 and 256-bit hashes use identical logic.
// - CRC polynomial up to 32 bits, left aligned, top term omitted.
// - CRC processes 12-bit byte count from first source offset.
// - Each data byte XORed with 8-bit mask before use.
// - Optional bit reversal of each data byte.
// - 32-bit CRC state register, seeded by software before start.
// - Final state XOR remainder mask, optional reversal, read-only remainder.
// - Eight shift iterations per cycle, one byte per cycle.
// - Registers and buffer retained in deep sleep; rst_n clears the registers in hibernate, the buffer has no reset.
// - Cipher accepts 128, 192 or 256-bit keys.
module chc_engine
   import chc_pkg::*;
(
   input wire logic ref_clk, // 125 MHz clock
   input wire logic rst_n, // Async reset, hibernate loss
   input wire logic [7:0] reg_addr, // Byte address; word index inside the buffer window (reg_addr[7] set)
   input wire logic [31:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [31:0] reg_rdata, // Read data, one cycle later
   output logic busy // Operation in progress
);
   typedef enum logic [4:0] {
      CHC_IDLE = 5'b00001,
      CHC_CRC = 5'b00010,
      CHC_COPY = 5'b00100,
      CHC_SCHED = 5'b01000,
      CHC_FIN = 5'b10000
   } chc_state_t;

   // ****************************
   // Registers
   // ****************************
   logic [31:0] ctrl_reg;
   logic [6:0] first_source_offset_reg, second_source_offset_reg;
   logic [6:0] first_destination_offset_reg, second_destination_offset_reg;
   logic [31:0] crc_data_config_reg, crc_polynomial_reg, crc_shift_state_reg;
   logic [31:0] crc_remainder_config_reg, crc_remainder_result_reg;
   logic done_reg, err_reg;
   logic [31:0] buf_mem [CHC_BUF_WORDS]; // No reset; retained when rst_n goes low
   chc_state_t state_reg;
   logic [11:0] cnt_reg;
   logic [6:0] idx_reg;
   logic [31:0] rd_word;

   wire logic [2:0] op = ctrl_reg[CHC_CTRL_OP_LSB +: 3];
   wire logic [1:0] key_size = reg_wdata[CHC_CTRL_KEY_LSB +: 2];
   wire logic start = reg_wr && reg_addr == CHC_CTRL_OFS && reg_wdata[CHC_CTRL_START_BIT]
      && reg_wdata[CHC_CTRL_EN_BIT] && state_reg == CHC_IDLE;
   wire logic key_ok = key_size == CHC_KEY_128 || key_size == CHC_KEY_192 || key_size == CHC_KEY_256;
   wire logic buf_wr_sw = reg_wr && reg_addr[7] && state_reg == CHC_IDLE;

   assign busy = state_reg != CHC_IDLE;

   // ****************************
   // CRC byte path
   // ****************************
   logic [6:0] crc_word_addr;
   logic [7:0] crc_byte_raw, crc_byte_in;
   logic [31:0] crc_step;
   logic [31:0] remainder_mask_field;
   logic [31:0] rem_rev;
   assign crc_word_addr = 7'(first_source_offset_reg + 7'(cnt_reg[11:2]));
   assign crc_byte_raw = rd_word[8 * cnt_reg[1:0] +: 8]; // Little-endian lanes

   always_comb begin
      logic [7:0] masked;
      logic [31:0] s;
      masked = crc_byte_raw ^ crc_data_config_reg[CHC_DATA_XOR_LSB +: 8];
      s = crc_shift_state_reg;
      crc_byte_in = masked;
      if (crc_data_config_reg[CHC_DATA_REV_BIT]) begin
         crc_byte_in = {<<{masked}};
      end
      for (int b = 7; b >= 0; b--) begin
         // MSB-first Galois step on left-aligned polynomial
         if (s[31] ^ crc_byte_in[b]) begin
            s = {s[30:0], 1'b0} ^ crc_polynomial_reg;
         end else begin
            s = {s[30:0], 1'b0};
         end
      end
      crc_step = s;
   end

   assign remainder_mask_field = crc_shift_state_reg ^ crc_remainder_config_reg;
   assign rem_rev = {<<{remainder_mask_field}};

   // ****************************
   // Buffer port for engine
   // ****************************
   logic [6:0] eng_addr;
   logic eng_we;
   logic [31:0] eng_wdata;
   logic [6:0] sched_words;
   logic [6:0] hash_words;
   assign sched_words = op == CHC_OP_SHA1 ? CHC_SCHED1_WORDS : CHC_SCHED2_WORDS;
   assign hash_words = op == CHC_OP_SHA1 ? 7'(CHC_HASH1_WORDS) : 7'(CHC_HASH2_WORDS);

   always_comb begin
      eng_addr = reg_addr[6:0];
      eng_we = 1'b0;
      eng_wdata = rd_word;
      case (state_reg)
         CHC_CRC: begin
            eng_addr = crc_word_addr;
         end
         CHC_SCHED: begin
            // Schedule scratch: message words repeated, W[t]=W[t-16] rotation base
            eng_addr = 7'(first_destination_offset_reg + idx_reg);
            eng_we = 1'b1;
         end
         CHC_COPY: begin
            eng_addr = 7'(second_destination_offset_reg + idx_reg);
            eng_we = 1'b1;
         end
         default: begin
            eng_addr = reg_addr[6:0];
         end
      endcase
   end

   // Source fetch for scratch and hash output, combinational from memory
   logic [6:0] src_addr;
   always_comb begin
      case (state_reg)
         CHC_SCHED: src_addr = 7'(first_source_offset_reg + 7'(idx_reg[3:0]));
         CHC_COPY: src_addr = 7'(second_source_offset_reg + idx_reg);
         CHC_CRC: src_addr = crc_word_addr;
         default: src_addr = reg_addr[6:0];
      endcase
   end
   assign rd_word = buf_mem[src_addr];

   always_ff @(posedge ref_clk) begin
      if (buf_wr_sw) begin
         buf_mem[reg_addr[6:0]] <= reg_wdata;
      end else if (eng_we) begin
         buf_mem[eng_addr] <= eng_wdata;
      end
   end

   // ****************************
   // Sequencer
   // ****************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= CHC_IDLE;
         cnt_reg <= 12'h000;
         idx_reg <= 7'h00;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         case (state_reg)
            CHC_IDLE: begin
               if (start) begin
                  done_reg <= 1'b0;
                  err_reg <= 1'b0;
                  cnt_reg <= 12'h000;
                  idx_reg <= 7'h00;
                  case (reg_wdata[CHC_CTRL_OP_LSB +: 3])
                     CHC_OP_CRC: state_reg <= reg_wdata[CHC_CTRL_START_BIT] &&
                        crc_data_config_reg[CHC_DATA_SIZE_LSB +: 12] != 12'h000 ? CHC_CRC : CHC_FIN;
                     CHC_OP_SHA1, CHC_OP_SHA2: state_reg <= CHC_SCHED;
                     default: state_reg <= CHC_FIN; // Cipher datapath lives elsewhere
                  endcase
                  if (reg_wdata[CHC_CTRL_OP_LSB +: 3] <= CHC_OP_AES_INV && !key_ok) begin
                     err_reg <= 1'b1;
                  end
               end
            end
            CHC_CRC: begin
               cnt_reg <= 12'(cnt_reg + 12'h001);
               if (12'(cnt_reg + 12'h001) == crc_data_config_reg[CHC_DATA_SIZE_LSB +: 12]) begin
                  state_reg <= CHC_FIN;
               end
            end
            CHC_SCHED: begin
               idx_reg <= 7'(idx_reg + 7'h01);
               if (7'(idx_reg + 7'h01) == sched_words) begin
                  idx_reg <= 7'h00;
                  state_reg <= CHC_COPY;
               end
            end
            CHC_COPY: begin
               idx_reg <= 7'(idx_reg + 7'h01);
               if (7'(idx_reg + 7'h01) == hash_words) begin
                  state_reg <= CHC_FIN;
               end
            end
            CHC_FIN: begin
               done_reg <= 1'b1;
               state_reg <= CHC_IDLE;
            end
            default: state_reg <= CHC_IDLE;
         endcase
      end
   end

   // ****************************
   // Software registers
   // ****************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= CHC_CTRL_RST;
         first_source_offset_reg <= 7'h00;
         second_source_offset_reg <= 7'h00;
         first_destination_offset_reg <= 7'h00;
         second_destination_offset_reg <= 7'h00;
         crc_data_config_reg <= 32'h0000_0000;
         crc_polynomial_reg <= 32'h0000_0000;
         crc_remainder_config_reg <= 32'h0000_0000;
      end else if (reg_wr && state_reg == CHC_IDLE) begin
         case (reg_addr)
            CHC_CTRL_OFS: ctrl_reg <= reg_wdata & ~(32'h1 << CHC_CTRL_START_BIT);
            CHC_SRC0_OFS: first_source_offset_reg <= reg_wdata[6:0];
            CHC_SRC1_OFS: second_source_offset_reg <= reg_wdata[6:0];
            CHC_DST0_OFS: first_destination_offset_reg <= reg_wdata[6:0];
            CHC_DST1_OFS: second_destination_offset_reg <= reg_wdata[6:0];
            CHC_CRC_DATA_OFS: crc_data_config_reg <= reg_wdata;
            CHC_CRC_POLY_OFS: crc_polynomial_reg <= reg_wdata;
            CHC_CRC_REMCFG_OFS: crc_remainder_config_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_shift_state_reg <= 32'h0000_0000;
      end else if (state_reg == CHC_CRC) begin
         crc_shift_state_reg <= crc_step;
      end else if (reg_wr && reg_addr == CHC_CRC_STATE_OFS && state_reg == CHC_IDLE) begin
         crc_shift_state_reg <= reg_wdata; // Seed
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_remainder_result_reg <= 32'h0000_0000;
      end else if (state_reg == CHC_FIN && op == CHC_OP_CRC) begin
         crc_remainder_result_reg <= crc_data_config_reg[CHC_REM_REV_BIT] ? rem_rev : remainder_mask_field;
      end
   end

   // ****************************
   // Read path
   // ****************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= 32'h0000_0000;
         if (reg_addr[7]) begin
            reg_rdata <= rd_word;
         end else begin
            case (reg_addr)
               CHC_CTRL_OFS: reg_rdata <= ctrl_reg;
               CHC_STATUS_OFS: reg_rdata <= {29'h0, err_reg, done_reg, busy};
               CHC_SRC0_OFS: reg_rdata <= {25'h0, first_source_offset_reg};
               CHC_SRC1_OFS: reg_rdata <= {25'h0, second_source_offset_reg};
               CHC_DST0_OFS: reg_rdata <= {25'h0, first_destination_offset_reg};
               CHC_DST1_OFS: reg_rdata <= {25'h0, second_destination_offset_reg};
               CHC_CRC_DATA_OFS: reg_rdata <= crc_data_config_reg;
               CHC_CRC_POLY_OFS: reg_rdata <= crc_polynomial_reg;
               CHC_CRC_STATE_OFS: reg_rdata <= crc_shift_state_reg;
               CHC_CRC_REMCFG_OFS: reg_rdata <= crc_remainder_config_reg;
               CHC_CRC_REMAINDER_RESULT_OFS: reg_rdata <= crc_remainder_result_reg;
               default: reg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************
   // Checks
   // ****************************
   property p_crc_len;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CHC_CRC && 12'(cnt_reg + 12'h001) == crc_data_config_reg[11:0]) |=> state_reg == CHC_FIN;
   endproperty
   a_crc_len: assert property (p_crc_len) else $error("crc length wrong");

   property p_done;
      @(posedge ref_clk) disable iff (!rst_n)
      state_reg == CHC_FIN |=> done_reg && !busy;
   endproperty
   a_done: assert property (p_done) else $error("done not set");

   property p_crc_step;
      @(posedge ref_clk) disable iff (!rst_n)
      state_reg == CHC_CRC |=> crc_shift_state_reg == $past(crc_step);
   endproperty
   a_crc_step: assert property (p_crc_step) else $error("crc state not stepped");

   property p_rem;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CHC_FIN && op == CHC_OP_CRC && !crc_data_config_reg[CHC_REM_REV_BIT])
         |=> crc_remainder_result_reg == (crc_shift_state_reg ^ crc_remainder_config_reg);
   endproperty
   a_rem: assert property (p_rem) else $error("remainder wrong");

   property p_rem_rev;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CHC_FIN && op == CHC_OP_CRC && crc_data_config_reg[CHC_REM_REV_BIT]) |=> crc_remainder_result_reg == rem_rev;
   endproperty
   a_rem_rev: assert property (p_rem_rev) else $error("reversed remainder wrong");

   property p_sched_len;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CHC_SCHED && 7'(idx_reg + 7'h01) == sched_words) |=> state_reg == CHC_COPY && idx_reg == 7'h00;
   endproperty
   a_sched_len: assert property (p_sched_len) else $error("schedule length wrong");

   property p_copy_len;
      @(posedge ref_clk) disable iff (!rst_n)
      (state_reg == CHC_COPY && 7'(idx_reg + 7'h01) == hash_words) |=> state_reg == CHC_FIN;
   endproperty
   a_copy_len: assert property (p_copy_len) else $error("hash copy length wrong");

   property p_wr_refused;
      @(posedge ref_clk) disable iff (!rst_n)
      (busy && reg_wr) |=> $stable(crc_polynomial_reg) && $stable(crc_remainder_config_reg);
   endproperty
   a_wr_refused: assert property (p_wr_refused) else $error("config changed while busy");

   property p_start_busy;
      @(posedge ref_clk) disable iff (!rst_n)
      start |=> busy;
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("busy not raised on start");
endmodule : chc_engine

// >>> rtl/chc_pkg.sv
package chc_pkg;
   // ****************************
   // Register offsets (byte addresses)
   // ****************************
   localparam logic [7:0] CHC_CTRL_OFS = 8'h00;
   localparam logic [7:0] CHC_STATUS_OFS = 8'h04;
   localparam logic [7:0] CHC_SRC0_OFS = 8'h08;
   localparam logic [7:0] CHC_SRC1_OFS = 8'h0c;
   localparam logic [7:0] CHC_DST0_OFS = 8'h10;
   localparam logic [7:0] CHC_DST1_OFS = 8'h14;
   localparam logic [7:0] CHC_CRC_DATA_OFS = 8'h18;
   localparam logic [7:0] CHC_CRC_POLY_OFS = 8'h1c;
   localparam logic [7:0] CHC_CRC_STATE_OFS = 8'h20;
   localparam logic [7:0] CHC_CRC_REMCFG_OFS = 8'h24;
   localparam logic [7:0] CHC_CRC_REMAINDER_RESULT_OFS = 8'h28;
   localparam logic [7:0] CHC_BUF_WIN_OFS = 8'h80;
   // ****************************
   // Fields
   // ****************************
   localparam int CHC_CTRL_EN_BIT = 31;
   localparam int CHC_CTRL_START_BIT = 8;
   localparam int CHC_CTRL_OP_LSB = 0;
   localparam int CHC_CTRL_KEY_LSB = 4;
   localparam int CHC_DATA_SIZE_LSB = 0;
   localparam int CHC_DATA_XOR_LSB = 16;
   localparam int CHC_DATA_REV_BIT = 24;
   // Remainder reversal sits in the data config word so the remainder mask keeps all 32 bits
   localparam int CHC_REM_REV_BIT = 25;
   localparam int CHC_STAT_BUSY_BIT = 0;
   localparam int CHC_STAT_DONE_BIT = 1;
   localparam int CHC_STAT_ERR_BIT = 2;
   // ****************************
   // Operation codes and key sizes
   // ****************************
   localparam logic [2:0] CHC_OP_AES_FWD = 3'h0;
   localparam logic [2:0] CHC_OP_AES_INV = 3'h1;
   localparam logic [2:0] CHC_OP_SHA1 = 3'h2;
   localparam logic [2:0] CHC_OP_SHA2 = 3'h3;
   localparam logic [2:0] CHC_OP_CRC = 3'h4;
   localparam logic [1:0] CHC_KEY_128 = 2'h0;
   localparam logic [1:0] CHC_KEY_192 = 2'h1;
   localparam logic [1:0] CHC_KEY_256 = 2'h2;
   // ****************************
   // Buffer and hash geometry
   // ****************************
   localparam int CHC_BUF_AW = 7;
   localparam int CHC_BUF_WORDS = 128;
   localparam int CHC_MSG_WORDS = 16;
   localparam logic [6:0] CHC_SCHED1_WORDS = 7'h50;
   localparam logic [6:0] CHC_SCHED2_WORDS = 7'h40;
   localparam logic [2:0] CHC_HASH1_WORDS = 3'h5;
   localparam logic [3:0] CHC_HASH2_WORDS = 4'h8;
   localparam logic [3:0] CHC_AES_WORDS = 4'h4;
   localparam logic [31:0] CHC_CTRL_RST = 32'h0000_0000;
endpackage : chc_pkg

// >>> verif/test_chc_engine.sv
`timescale 1ns/100ps
module test_chc_engine;
   import chc_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic busy;
   int failures = 0;
   int checks = 0;
   int busy_cycles = 0;
   logic [7:0] msg [5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a};
   logic [31:0] v;

   chc_engine i_chc_engine (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy));

   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (busy === 1'b1) busy_cycles++;

   // ****************************
   // Bus and compare helpers
   // ****************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   function automatic logic [7:0] ba(input int w);
      return CHC_BUF_WIN_OFS + 8'(w);
   endfunction : ba

   task automatic start_op(input logic [31:0] ctrl);
      busy_cycles = 0;
      wr(CHC_CTRL_OFS, ctrl);
      #1;
      chk_bit(busy, 1'b1);
   endtask : start_op

   task automatic wait_idle();
      int n;
      n = 0;
      #1;
      while (busy !== 1'b0 && n < 500) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk_bit(busy, 1'b0);
   endtask : wait_idle

   // Reference remainder: mask and optionally reverse each byte, eight shifts per byte
   function automatic logic [31:0] crc_model(input logic [31:0] poly, seed, dcfg, rcfg);
      logic [31:0] s;
      logic [7:0] b;
      logic fb;
      s = seed;
      for (int i = 0; i < int'(dcfg[11:0]); i++) begin
         b = msg[i] ^ dcfg[23:16];
         if (dcfg[CHC_DATA_REV_BIT]) b = {<<{b}};
         for (int j = 7; j >= 0; j--) begin
            fb = s[31] ^ b[j];
            s = {s[30:0], 1'b0} ^ (fb ? poly : 32'h0000_0000);
         end
      end
      s = s ^ rcfg;
      if (dcfg[CHC_REM_REV_BIT]) s = {<<{s}};
      return s;
   endfunction : crc_model

   task automatic crc_case(input logic [31:0] poly, seed, dcfg, rcfg, src, exp, input logic poke);
      logic [31:0] r;
      wr(CHC_CRC_DATA_OFS, dcfg);
      wr(CHC_CRC_POLY_OFS, poly);
      wr(CHC_CRC_STATE_OFS, seed);
      wr(CHC_CRC_REMCFG_OFS, rcfg);
      wr(CHC_SRC0_OFS, src);
      start_op(32'h8000_0100 | 32'(CHC_OP_CRC));
      if (poke) wr(CHC_CRC_POLY_OFS, ~poly);
      wait_idle();
      chk_word(32'(busy_cycles), 32'(dcfg[11:0]) + 32'h1);
      rd(CHC_CRC_REMAINDER_RESULT_OFS, r);
      chk_word(r, exp);
      rd(CHC_CRC_POLY_OFS, r);
      chk_word(r, poly);
      rd(CHC_STATUS_OFS, r);
      chk_bit(r[CHC_STAT_DONE_BIT], 1'b1);
   endtask : crc_case

   // ****************************
   // Scenarios
   // ****************************
   task automatic test_reset();
      for (int a = 0; a <= 40; a += 4) begin
         rd(8'(a), v);
         chk_word(v, 32'h0000_0000);
      end
      rd(8'h40, v);
      chk_word(v, 32'h0000_0000);
      $display("test_reset done");
   endtask : test_reset

   task automatic test_regs();
      logic [7:0] ofs [7] = '{CHC_SRC0_OFS, CHC_SRC1_OFS, CHC_DST0_OFS, CHC_DST1_OFS, CHC_CRC_DATA_OFS,
         CHC_CRC_POLY_OFS, CHC_CRC_STATE_OFS};
      logic [31:0] val [7] = '{32'h55, 32'h2a, 32'h11, 32'h33, 32'h01a5_0abc, 32'hdead_beef, 32'h1357_9bdf};
      for (int i = 0; i < 7; i++) wr(ofs[i], val[i]);
      for (int i = 0; i < 7; i++) begin
         rd(ofs[i], v);
         chk_word(v, val[i]);
      end
      wr(CHC_CRC_REMAINDER_RESULT_OFS, 32'hcafe_f00d);
      rd(CHC_CRC_REMAINDER_RESULT_OFS, v);
      chk_word(v, 32'h0000_0000);
      $display("test_regs done");
   endtask : test_regs

   task automatic test_crc();
      wr(ba(0), 32'h7856_3412);
      wr(ba(1), 32'h0000_009a);
      wr(ba(4), 32'h7856_3412);
      wr(ba(5), 32'h0000_009a);
      crc_case(32'h04c1_1db7, 32'hffff_ffff, 32'h0300_0005, 32'hffff_ffff, 0, 32'h3c46_87af, 0);
      crc_case(32'h1021_0000, 32'hffff_0000, 32'h0000_0005, 32'h0, 0, 32'hf8a0_0000, 0);
      crc_case(32'h8005_0000, 32'hffff_0000, 32'h0300_0005, 32'h0, 0, 32'h0000_48d0, 0);
      crc_case(32'h04c1_1db7, 32'h1234_5678, 32'h0, 32'h0f0f_0f0e, 0, 32'h1d3b_5976, 0);
      crc_case(32'h1021_0000, 32'hffff_0000, 32'h00ff_0003, 32'h0, 0,
         crc_model(32'h1021_0000, 32'hffff_0000, 32'h00ff_0003, 32'h0), 0);
      crc_case(32'h04c1_1db7, 32'hffff_ffff, 32'h01a5_0005, 32'h0, 4,
         crc_model(32'h04c1_1db7, 32'hffff_ffff, 32'h01a5_0005, 32'h0), 1);
      $display("test_crc done");
   endtask : test_crc

   task automatic test_sha();
      int n;
      for (int s = 0; s < 2; s++) begin
         n = (s == 0) ? 5 : 8;
         for (int k = 0; k < 8; k++) wr(ba(16 + k), 32'h5a00_0000 | 32'(s << 8) | 32'(k));
         for (int k = 0; k < 8; k++) wr(ba(24 + k), 32'hdead_0000 | 32'(k));
         wr(CHC_SRC0_OFS, 32'h0);
         wr(CHC_SRC1_OFS, 32'd16);
         wr(CHC_DST0_OFS, 32'd40);
         wr(CHC_DST1_OFS, 32'd24);
         start_op(32'h8000_0100 | 32'((s == 0) ? CHC_OP_SHA1 : CHC_OP_SHA2));
         wait_idle();
         rd(ba(60), v);
         chk_word(v, 32'h7856_3412);
         for (int k = 0; k < 8; k++) begin
            rd(ba(24 + k), v);
            chk_word(v, (k < n) ? (32'h5a00_0000 | 32'(s << 8) | 32'(k)) : (32'hdead_0000 | 32'(k)));
         end
      end
      $display("test_sha done");
   endtask : test_sha

   task automatic test_aes();
      for (int k = 0; k < 4; k++) begin
         start_op(32'h8000_0100 | 32'(k << CHC_CTRL_KEY_LSB) | 32'(k % 2));
         wait_idle();
         rd(CHC_STATUS_OFS, v);
         chk_bit(v[CHC_STAT_ERR_BIT], k == 3);
      end
      wr(CHC_CTRL_OFS, 32'h0000_0104);
      #1;
      chk_bit(busy, 1'b0);
      $display("test_aes done");
   endtask : test_aes

   task automatic test_hibernate();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(CHC_CRC_POLY_OFS, v);
      chk_word(v, 32'h0000_0000);
      rd(CHC_CRC_REMCFG_OFS, v);
      chk_word(v, 32'h0000_0000);
      $display("test_hibernate done");
   endtask : test_hibernate

   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      test_reset();
      test_regs();
      test_crc();
      test_sha();
      test_aes();
      test_hibernate();
      finish_test();
   end

   // Run needs under a thousand cycles; allow far more
   initial begin
      #200000;
      failures++;
      $display("watchdog expired at %0t", $time);
      finish_test();
   end
endmodule : test_chc_engine
